//--- src/ddc_pkg.sv
// ddc_pkg: shared constants for the dual converter control link and both ends
// assumes: one system clock domain on each end, link pins pass a two-stage synchroniser in the device
`default_nettype none
package ddc_pkg;
  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int FRAME_BITS = 24;
  localparam int CMD_HI = 21;
  localparam int CMD_LO = 19;
  localparam int ADDR_HI = 18;
  localparam int ADDR_LO = 16;
  localparam int PDM_HI = 5;
  localparam int PDM_LO = 4;
  localparam int SEL_B = 1;
  localparam int SEL_A = 0;
  localparam int RST_MODE_BIT = 0;
  localparam logic [4:0] CNT_LAST = 5'h17;
  // ****************************************************************
  // commands, addresses, modes
  // ****************************************************************
  localparam logic [2:0] OP_WRITE_IN = 3'h0;
  localparam logic [2:0] OP_UPDATE = 3'h1;
  localparam logic [2:0] OP_WRITE_ALL = 3'h2;
  localparam logic [2:0] OP_WRITE_UPD = 3'h3;
  localparam logic [2:0] OP_POWER = 3'h4;
  localparam logic [2:0] OP_RESET = 3'h5;
  localparam logic [2:0] OP_LOAD_SEL = 3'h6;
  localparam logic [2:0] ADDR_A = 3'h0;
  localparam logic [2:0] ADDR_B = 3'h1;
  localparam logic [2:0] ADDR_ALL = 3'h7;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_TRI = 2'h3;
  // ****************************************************************
  // host register map (word index on the host command port)
  // ****************************************************************
  localparam logic [1:0] HREG_FRAME_LO = 2'h0;
  localparam logic [1:0] HREG_FRAME_HI = 2'h1;
  localparam logic [1:0] HREG_CTRL = 2'h2;
  localparam logic [1:0] HREG_STATUS = 2'h3;
  localparam int CTRL_LOAD_BIT = 0;
  localparam int DIV_HALF = 4;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int WAKE_TIME_NS = 4000;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_IDLE_CYCLES = 4;
endpackage : ddc_pkg
`default_nettype wire

//--- src/ddc_link_if.sv
// ddc_link_if: three-wire write-only link plus the active-low load pin
// assumes: host drives every wire, device only listens
`default_nettype none
interface ddc_link_if;
  logic sclk;
  logic frameSyncN;
  logic din;
  logic loadStrobeN;
  modport host (output sclk, output frameSyncN, output din, output loadStrobeN);
  modport dev (input sclk, input frameSyncN, input din, input loadStrobeN);
endinterface : ddc_link_if
`default_nettype wire

//--- src/ddc_device.sv
// ddc_device: converter-side control: frame receiver, input/converter registers,
// power-down modes and load override
// assumes: link pins come from another domain and are synchronised here
`default_nettype none
module ddc_device (
  input wire logic sys_clk,
  input wire logic rst_n,
  ddc_link_if.dev link,
  output logic [15:0] convA,
  output logic [15:0] convB,
  output logic [1:0] pdModeA,
  output logic [1:0] pdModeB,
  output logic [1:0] loadOverride,
  output logic [1:0] pending
);
  import ddc_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic sclkPrev_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 4'hF;
      sync_q <= 4'hF;
      sclkPrev_q <= 1'b1;
    end else begin
      meta_q <= {link.sclk, link.frameSyncN, link.din, link.loadStrobeN};
      sync_q <= meta_q;
      sclkPrev_q <= sync_q[3];
    end
  end
  wire sclkS = sync_q[3];
  wire syncN = sync_q[2];
  wire dinS = sync_q[1];
  wire loadN = sync_q[0];
  wire sclkFall = sclkPrev_q & ~sclkS;

  // ****************************************************************
  // frame receiver
  // ****************************************************************
  logic [23:0] shift_q;
  logic [4:0] cnt_q;
  logic done_q;
  logic frameOk;
  wire shiftEn = ~syncN & ~done_q & sclkFall;
  assign frameOk = shiftEn && (cnt_q == CNT_LAST);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 24'h000000;
      cnt_q <= 5'h00;
      done_q <= 1'b0;
    end else if (syncN) begin
      shift_q <= 24'h000000;
      cnt_q <= 5'h00;
      done_q <= 1'b0;
    end else if (shiftEn) begin
      shift_q <= {shift_q[22:0], dinS};
      cnt_q <= frameOk ? 5'h00 : cnt_q + 5'h01;
      done_q <= frameOk; // extra edges ignored until sync rises
    end
  end
  wire [23:0] frame = {shift_q[22:0], dinS};
  wire [2:0] op = frame[CMD_HI:CMD_LO];
  wire [2:0] chAddr = frame[ADDR_HI:ADDR_LO];
  wire [15:0] word = frame[15:0];
  wire addrOk = (chAddr == ADDR_A) | (chAddr == ADDR_B) | (chAddr == ADDR_ALL);
  wire [1:0] hit = {(chAddr == ADDR_B) | (chAddr == ADDR_ALL),
                    (chAddr == ADDR_A) | (chAddr == ADDR_ALL)};
  wire dataOp = (op == OP_WRITE_IN) | (op == OP_UPDATE) | (op == OP_WRITE_ALL)
                | (op == OP_WRITE_UPD);
  wire dataGo = frameOk & dataOp & addrOk;
  wire writeIn = dataGo & (op != OP_UPDATE);
  wire powerGo = frameOk & (op == OP_POWER);
  wire resetGo = frameOk & (op == OP_RESET);
  wire fullReset = resetGo & frame[RST_MODE_BIT];
  wire loadSelGo = frameOk & (op == OP_LOAD_SEL);

  // ****************************************************************
  // per-channel registers
  // ****************************************************************
  logic [15:0] inReg_q [2];
  logic [15:0] conv_q [2];
  logic [1:0] pd_q [2];
  logic [1:0] pend_q;
  logic [1:0] ovr_q;
  wire [1:0] selBits = {frame[SEL_B], frame[SEL_A]};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      wire wr = writeIn & hit[ch];
      wire pinLow = ~loadN | ovr_q[ch];
      wire upCmd = dataGo & (((op == OP_UPDATE) | (op == OP_WRITE_UPD)) & hit[ch]
                   | (op == OP_WRITE_ALL));
      wire upReq = upCmd | pinLow;
      wire pendNow = pend_q[ch] | wr;
      wire upd = upReq & pendNow;
      wire [15:0] src = wr ? word : inReg_q[ch];
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          inReg_q[ch] <= 16'h0000;
          conv_q[ch] <= 16'h0000;
          pd_q[ch] <= PD_NORMAL;
          pend_q[ch] <= 1'b0;
          ovr_q[ch] <= 1'b0;
        end else if (resetGo) begin
          inReg_q[ch] <= 16'h0000;
          conv_q[ch] <= 16'h0000;
          pend_q[ch] <= 1'b0;
          if (fullReset) begin
            pd_q[ch] <= PD_NORMAL;
            ovr_q[ch] <= 1'b0;
          end
        end else begin
          if (wr) begin
            inReg_q[ch] <= word;
          end
          if (upd) begin
            conv_q[ch] <= src;
          end
          pend_q[ch] <= pendNow & ~upd;
          if (powerGo && selBits[ch]) begin
            pd_q[ch] <= frame[PDM_HI:PDM_LO];
          end
          if (loadSelGo) begin
            ovr_q[ch] <= frame[ch];
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign convA = conv_q[0];
  assign convB = conv_q[1];
  assign pdModeA = pd_q[0];
  assign pdModeB = pd_q[1];
  assign loadOverride = ovr_q;
  assign pending = pend_q;
endmodule : ddc_device
`default_nettype wire

//--- src/ddc_host.sv
// ddc_host: link master; software loads a 24-bit frame and starts it
// assumes: register port with one-cycle strobes, read data one cycle later
`default_nettype none
module ddc_host (
  input wire logic sys_clk,
  input wire logic rst_n,
  ddc_link_if.host link,
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata
);
  import ddc_pkg::*;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SHIFT = 2'b01,
    HS_GAP = 2'b10
  } ddc_hstate_e;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [23:0] frame_q;
  logic loadN_q;
  logic [15:0] rdata_q;
  ddc_hstate_e st_q;
  logic [4:0] bit_q;
  logic [2:0] div_q;
  logic sclk_q;
  logic [3:0] gap_q;
  wire busy = (st_q != HS_IDLE);
  wire start = regWr & (regAddr == HREG_CTRL) & regWdata[1] & ~busy;
  wire [15:0] rdMux = (regAddr == HREG_FRAME_LO) ? frame_q[15:0] :
                      (regAddr == HREG_FRAME_HI) ? {8'h00, frame_q[23:16]} :
                      (regAddr == HREG_CTRL) ? {15'h0000, loadN_q} :
                      {15'h0000, busy};
  wire tick = (div_q == 3'(DIV_HALF - 1));
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= 24'h000000;
      loadN_q <= 1'b1;
      rdata_q <= 16'h0000;
    end else begin
      if (regWr && regAddr == HREG_FRAME_LO && !busy) frame_q[15:0] <= regWdata;
      if (regWr && regAddr == HREG_FRAME_HI && !busy) frame_q[23:16] <= regWdata[7:0];
      if (regWr && regAddr == HREG_CTRL) loadN_q <= regWdata[CTRL_LOAD_BIT];
      if (regRd) rdata_q <= rdMux;
    end
  end
  assign regRdata = rdata_q;

  // ****************************************************************
  // frame sender: data changes on rising sclk, device takes falling
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= HS_IDLE;
      bit_q <= 5'h00;
      div_q <= 3'h0;
      sclk_q <= 1'b1;
      gap_q <= 4'h0;
    end else begin
      unique case (st_q)
        HS_IDLE: begin
          div_q <= 3'h0;
          sclk_q <= 1'b1;
          if (start) begin
            st_q <= HS_SHIFT;
            bit_q <= 5'h00;
          end
        end
        HS_SHIFT: begin
          div_q <= tick ? 3'h0 : div_q + 3'h1;
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              if (bit_q == CNT_LAST) begin
                st_q <= HS_GAP;
                gap_q <= 4'h0;
              end else begin
                bit_q <= bit_q + 5'h01;
              end
            end
          end
        end
        HS_GAP: begin
          sclk_q <= 1'b1;
          gap_q <= gap_q + 4'h1;
          if (gap_q == 4'(SYNC_IDLE_CYCLES - 1)) st_q <= HS_IDLE;
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end
  assign link.sclk = sclk_q;
  assign link.frameSyncN = (st_q != HS_SHIFT);
  assign link.din = frame_q[5'd23 - bit_q];
  assign link.loadStrobeN = loadN_q;
endmodule : ddc_host
`default_nettype wire

//--- bench/ddc_link_props.sv
// ddc_link_props: checks on the link wires and the device state
// assumes: one clock domain, asynchronous active-low reset
`default_nettype none
module ddc_link_chk
  import ddc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic frameSyncN,
  input wire logic loadStrobeN,
  input wire logic [15:0] convA,
  input wire logic [15:0] convB,
  input wire logic [1:0] pdModeA,
  input wire logic [1:0] loadOverride,
  input wire logic [1:0] pending
);
  // ********
  // falls of the link clock inside a frame
  // ********
  logic sclkQ;
  logic [5:0] fallQ;
  logic [5:0] fallD;
  wire logic fallSeen = sclkQ && !sclk && !frameSyncN;
  assign fallD = frameSyncN ? 6'h00 : fallQ + {5'h00, fallSeen};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkQ <= 1'b1;
      fallQ <= 6'h00;
    end else begin
      sclkQ <= sclk;
      fallQ <= fallD;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_FRAME_LEN: assert property ($rose(frameSyncN) |-> fallQ == 6'h18)
    else $error("frame did not hold 24 clock falls");
  AST_SYNC_GAP: assert property ($rose(frameSyncN) |-> frameSyncN [*4])
    else $error("frame sync gap too short");
  AST_SCLK_HALF: assert property ($changed(sclk) |=> $stable(sclk) [*3])
    else $error("link clock half period wrong");
  AST_OVR_RESET: assert property ($rose(rst_n) |-> loadOverride == 2'h0)
    else $error("override not zero after reset");
  AST_PD_KEEP: assert property ($changed(pdModeA) && pdModeA != PD_NORMAL |-> $stable(convA))
    else $error("power-down changed converter value");
  AST_OVR_KEEP: assert property ($changed(loadOverride) && loadOverride != 2'h0
    |-> $stable(convA) && $stable(convB))
    else $error("override write changed converter value");
  AST_LOAD_LOW: assert property ((!loadStrobeN) [*4] ##0 pending[0] |=> !pending[0])
    else $error("pending channel not updated with load low");
  AST_IN_FRAME: assert property ($changed(pdModeA) || $changed(loadOverride)
    |-> !$past(frameSyncN, 3) || !$past(frameSyncN, 4) || !$past(frameSyncN, 5))
    else $error("mode changed outside a frame");
endmodule : ddc_link_chk
`default_nettype wire

//--- bench/tb_top.sv
// tb_top: host and device joined by the link, driven through the host port
// assumes: ddc_pkg, the link interface and both ends compiled first
`default_nettype none
module tb_top
  import ddc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, regWr, regRd, ld;
  logic [1:0] regAddr, pdModeA, pdModeB, loadOverride, pending;
  logic [15:0] regWdata, regRdata, rv, convA, convB;
  int n_errors, checks_done;
  ddc_link_if ddc_link_if_i ();
  ddc_host ddc_host_i (.sys_clk, .rst_n, .link(ddc_link_if_i), .regAddr, .regWdata,
    .regWr, .regRd, .regRdata);
  ddc_device ddc_device_i (.sys_clk, .rst_n, .link(ddc_link_if_i), .convA, .convB,
    .pdModeA, .pdModeB, .loadOverride, .pending);
  ddc_link_chk ddc_link_chk_i (.sys_clk, .rst_n, .sclk(ddc_link_if_i.sclk),
    .frameSyncN(ddc_link_if_i.frameSyncN), .loadStrobeN(ddc_link_if_i.loadStrobeN),
    .convA, .convB, .pdModeA, .loadOverride, .pending);
  // ********
  // host port access
  // ********
  task automatic final_report();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [1:0] a, logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(logic [1:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 rv = regRdata;
  endtask : rd
  task automatic setld(logic v);
    ld = v;
    wr(HREG_CTRL, {15'h0000, v});
    repeat (6) @(posedge sys_clk);
  endtask : setld
  // ignored top bits set to one on every frame
  task automatic send(logic [2:0] op, logic [2:0] ad, logic [15:0] d);
    wr(HREG_FRAME_LO, d);
    wr(HREG_FRAME_HI, {8'h00, 2'h3, op, ad});
    wr(HREG_CTRL, {14'h0000, 1'b1, ld});
    for (int i = 0; i < 200; i++) begin
      rd(HREG_STATUS);
      if (rv[0] === 1'b0) break;
    end
    if (rv[0] !== 1'b0) begin
      n_errors++;
      final_report();
    end
    repeat (4) @(posedge sys_clk);
    chk("sync", {15'h0000, ddc_link_if_i.frameSyncN}, 16'h0001);
  endtask : send
  // m packs pdModeA, pdModeB, loadOverride, pending
  task automatic st(logic [15:0] a, logic [15:0] b, logic [7:0] m);
    chk("convA", convA, a);
    chk("convB", convB, b);
    chk("modes", {8'h00, pdModeA, pdModeB, loadOverride, pending}, {8'h00, m});
  endtask : st
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 2'h0;
    regWdata = 16'h0000;
    ld = 1'b1;
    n_errors = 0;
    checks_done = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    st(16'h0000, 16'h0000, 8'h00);
    setld(1'b1);
    send(OP_WRITE_IN, ADDR_A, 16'h1234);
    st(16'h0000, 16'h0000, 8'h01);
    send(OP_WRITE_IN, ADDR_B, 16'h5678);
    send(OP_UPDATE, ADDR_A, 16'hDEAD);
    st(16'h1234, 16'h0000, 8'h02);
    send(OP_WRITE_ALL, ADDR_A, 16'h1111);
    st(16'h1111, 16'h5678, 8'h00);
    send(OP_WRITE_UPD, ADDR_B, 16'h2222);
    st(16'h1111, 16'h2222, 8'h00);
    send(OP_LOAD_SEL, 3'h5, 16'hFFFE);
    send(OP_WRITE_IN, ADDR_ALL, 16'h5555);
    st(16'h1111, 16'h5555, 8'h09);
    for (int m = 1; m < 4; m++) begin
      send(OP_POWER, 3'h5, {10'h3FF, m[1:0], 4'hF});
      st(16'h1111, 16'h5555, {m[1:0], m[1:0], 4'h9});
    end
    send(OP_POWER, 3'h2, 16'hFFCD);
    repeat (WAKE_CYCLES) @(posedge sys_clk);
    st(16'h1111, 16'h5555, 8'h39);
    send(3'h7, ADDR_A, 16'h0BAD);
    send(OP_WRITE_IN, 3'h2, 16'h0BAD);
    st(16'h1111, 16'h5555, 8'h39);
    setld(1'b0);
    st(16'h5555, 16'h5555, 8'h38);
    send(OP_WRITE_IN, ADDR_A, 16'h6666);
    st(16'h6666, 16'h5555, 8'h38);
    send(OP_RESET, 3'h5, 16'hFFFE);
    st(16'h0000, 16'h0000, 8'h38);
    send(OP_RESET, ADDR_A, 16'h0001);
    st(16'h0000, 16'h0000, 8'h00);
    final_report();
  end
endmodule : tb_top
`default_nettype wire
